// *** verilog/spu_pkg.sv ***
// spu_pkg: shared constants and carrier types for the serial port unit
// assumes: included first in compile order; no other package dependencies
package spu_pkg;

   // select mode field encodings
   localparam logic [1:0] SEL_3WIRE = 2'h0;
   localparam logic [1:0] SEL_4WIRE_IN = 2'h1;
   localparam int SEL_HI_BIT = 1;
   localparam int SEL_LO_BIT = 0;

   // control bit positions and reset values
   localparam int CTL_DONE_BIT = 7;
   localparam int CTL_ROLE_BIT = 6;
   localparam logic [1:0] SEL_MODE_RST = 2'h0;
   localparam logic [7:0] DATA_RST = 8'h00;

   // transfer geometry and sck timing
   localparam int BITS_PER_XFER = 8;
   localparam int SYS_CLK_NS = 25;
   localparam int SCK_HALF_NS = 100;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   // controller-facing configuration
   typedef struct packed {
      logic enable;
      logic controller_role_enable;
      logic [1:0] select_mode_field;
   } spu_cfg_t;

   // pad-side two-signal output group (o, oe) for one two-way pin
   typedef struct packed {
      logic o;
      logic oe;
   } spu_pad_t;

endpackage

// *** verilog/spu_sync2.sv ***
// spu_sync2: two flip-flop level synchroniser into the local clock domain
// assumes: input is asynchronous to clk; first stage feeds only the second
module spu_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in and out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // meta stage read only by the output stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// *** verilog/spu_port.sv ***
// spu_port: serial port unit pin roles, select modes and byte shifter
// assumes: controller writes config and data on sys_clk; link side runs on
// slave_sck, which the far master only toggles while a frame is in progress
module spu_port (
   // system clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // link clock from a far master
   input wire logic slave_sck,
   // configuration from controller
   input wire logic cfg_wr,
   input wire spu_pkg::spu_cfg_t cfg_in,
   input wire logic data_wr,
   input wire logic [7:0] data_in,
   input wire logic done_clr,
   // status to controller
   output logic [7:0] port_control_reg,
   output logic [7:0] rx_data,
   output logic busy,
   // mosi pin
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   // miso pin
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   // sck pin
   output logic sck_o,
   output logic sck_oe,
   // select pin
   input wire logic sel_n_i,
   output logic sel_n_o,
   output logic sel_n_oe,
   output logic sel_pinned
);

   // controller-side state
   spu_pkg::spu_cfg_t cfg_q;
   logic done_q;
   logic mode_fault_q;
   logic [7:0] shift_q;
   logic miso_cap_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] half_cnt_q;
   logic sck_q;
   logic active_q;
   logic [7:0] rx_q;
   logic sel_prev_q;
   logic is_master;
   logic sel_s;
   logic miso_s;
   // link crossing state
   logic s_miso_msb;
   logic s_toggle;
   logic [7:0] s_rx_byte;
   logic s_toggle_s;
   logic s_toggle_prev_q;
   logic s_new_q;
   logic [7:0] s_rx_hold_q;
   logic slave_selected;

   // role bit decides which side drives mosi and sck
   assign is_master = cfg_q.controller_role_enable;

   // config store; field resets to 3-wire so select stays off the pin
   // a config write beats a same-cycle fault, so software keeps its own value
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q.enable <= 1'b0;
         cfg_q.controller_role_enable <= 1'b0;
         cfg_q.select_mode_field <= spu_pkg::SEL_MODE_RST;
      end else if (cfg_wr) begin
         cfg_q <= cfg_in;
      end else if (mode_fault_q) begin
         cfg_q.controller_role_enable <= 1'b0;
      end
   end

   // select and miso pass two flops before sys_clk logic reads them; the slave link takes select and mosi raw
   spu_sync2 #(.WIDTH(2)) u_pin_sync (
      .clk(sys_clk),
      .rst(rst),
      .d({sel_n_i, miso_i}),
      .q({sel_s, miso_s})
   );

   // falling select in multi-master mode drops the master role
   // select arrives two flops late; the fault lands one cycle after that
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_prev_q <= 1'b0; // sync resets low, so no false fall after reset
         mode_fault_q <= 1'b0;
      end else begin
         sel_prev_q <= sel_s;
         mode_fault_q <= is_master && cfg_q.enable
            && cfg_q.select_mode_field == spu_pkg::SEL_4WIRE_IN
            && sel_prev_q && !sel_s;
      end
   end

   // master shifter: rise captures miso, fall shifts, so mosi never moves
   // under the far side's sampling edge; 8 bits, msb out, lsb in
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shift_q <= spu_pkg::DATA_RST;
         miso_cap_q <= 1'b0;
         bit_cnt_q <= 4'h0;
         half_cnt_q <= 8'h00;
         sck_q <= 1'b0;
         active_q <= 1'b0;
      end else if (!is_master || !cfg_q.enable) begin
         active_q <= 1'b0;
         sck_q <= 1'b0;
      end else if (!active_q) begin
         if (data_wr) begin
            shift_q <= data_in;
            active_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            half_cnt_q <= 8'h00;
         end
      end else if (half_cnt_q == 8'(spu_pkg::SCK_HALF_CYC - 1)) begin
         half_cnt_q <= 8'h00;
         sck_q <= !sck_q;
         if (!sck_q) begin
            // rising edge samples miso
            miso_cap_q <= miso_s;
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end else begin
            // falling edge: msb leaves, captured bit enters lsb
            shift_q <= {shift_q[6:0], miso_cap_q};
            if (bit_cnt_q == 4'(spu_pkg::BITS_PER_XFER)) begin
               active_q <= 1'b0;
            end
         end
      end else begin
         half_cnt_q <= half_cnt_q + 8'h01;
      end
   end

   // link-side slave shifter on the far master's clock
   assign slave_selected = cfg_q.enable && !is_master
      && (cfg_q.select_mode_field == spu_pkg::SEL_3WIRE || !sel_s);

   // mode_3wire is quasi-static: software changes it only while the link is idle
   spu_slave_link u_link (
      .slave_sck(slave_sck),
      .rst(rst),
      .sel_n_raw(sel_n_i),
      .mode_3wire(cfg_q.select_mode_field == spu_pkg::SEL_3WIRE),
      .mosi_i(mosi_i),
      .miso_msb(s_miso_msb),
      .rx_toggle(s_toggle),
      .rx_byte(s_rx_byte),
      .selected()
   );

   // byte-done toggle crosses by two flops; byte held stable until next toggle
   spu_sync2 #(.WIDTH(1)) u_tog_sync (
      .clk(sys_clk),
      .rst(rst),
      .d(s_toggle),
      .q(s_toggle_s)
   );

   // hold takes the byte on the toggle edge; done follows one cycle later
   // so that rx_q reads the new hold and not the previous byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_toggle_prev_q <= 1'b0;
         s_new_q <= 1'b0;
         s_rx_hold_q <= spu_pkg::DATA_RST;
      end else begin
         s_toggle_prev_q <= s_toggle_s;
         s_new_q <= s_toggle_s != s_toggle_prev_q;
         if (s_toggle_s != s_toggle_prev_q) begin
            s_rx_hold_q <= s_rx_byte;
         end
      end
   end

   // done flag: set wins over clear
   // master byte includes the bit captured on the last rise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_q <= 1'b0;
         rx_q <= spu_pkg::DATA_RST;
      end else if (active_q && sck_q && bit_cnt_q == 4'(spu_pkg::BITS_PER_XFER)
                   && half_cnt_q == 8'(spu_pkg::SCK_HALF_CYC - 1)) begin
         done_q <= 1'b1;
         rx_q <= {shift_q[6:0], miso_cap_q};
      end else if (s_new_q && slave_selected) begin
         done_q <= 1'b1;
         rx_q <= s_rx_hold_q;
      end else if (done_clr) begin
         done_q <= 1'b0;
      end
   end

   // pad drive, all from flops
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mosi_o <= 1'b0;
         mosi_oe <= 1'b0;
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
         sck_o <= 1'b0;
         sck_oe <= 1'b0;
         sel_n_o <= 1'b1;
         sel_n_oe <= 1'b0;
         sel_pinned <= 1'b0;
      end else begin
         mosi_o <= shift_q[7];
         mosi_oe <= cfg_q.enable && is_master;
         // miso data from link msb; slower path acceptable, sampled by master sck
         miso_o <= s_miso_msb;
         miso_oe <= slave_selected;
         sck_o <= sck_q;
         sck_oe <= cfg_q.enable && is_master;
         sel_n_o <= cfg_q.select_mode_field[spu_pkg::SEL_LO_BIT];
         sel_n_oe <= cfg_q.enable && cfg_q.select_mode_field[spu_pkg::SEL_HI_BIT];
         sel_pinned <= cfg_q.select_mode_field != spu_pkg::SEL_3WIRE;
      end
   end

   // status outputs
   // these trail the internal flops by one cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         port_control_reg <= 8'h00;
         rx_data <= spu_pkg::DATA_RST;
         busy <= 1'b0;
      end else begin
         port_control_reg <= {done_q, cfg_q.controller_role_enable, 2'h0,
                              cfg_q.select_mode_field, 1'b0, cfg_q.enable};
         rx_data <= rx_q;
         busy <= active_q;
      end
   end

endmodule

// spu_slave_link: slave shifter clocked by the far master's sck
// assumes: sck idles low; sample and shift on rise, miso follows the msb
// rst is taken on this clock, so it must span at least one sck edge
module spu_slave_link (
   // link clock and reset
   input wire logic slave_sck,
   input wire logic rst,
   // select and mode
   input wire logic sel_n_raw,
   input wire logic mode_3wire,
   // data
   input wire logic mosi_i,
   output logic miso_msb,
   output logic rx_toggle,
   output logic [7:0] rx_byte,
   output logic selected
);

   logic [7:0] sh_q;
   logic [2:0] cnt_q;

   // sck ignored while unselected in 4-wire; 3-wire always selected
   assign selected = mode_3wire || !sel_n_raw;
   assign miso_msb = sh_q[7];

   // byte complete on the eighth rise; the toggle tells the system side
   always_ff @(posedge slave_sck) begin
      if (rst) begin
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
         rx_toggle <= 1'b0;
         rx_byte <= 8'h00;
      end else if (selected) begin
         sh_q <= {sh_q[6:0], mosi_i};
         cnt_q <= cnt_q + 3'h1;
         if (cnt_q == 3'h7) begin
            rx_byte <= {sh_q[6:0], mosi_i};
            rx_toggle <= !rx_toggle;
         end
      end
   end

endmodule

// *** bench/spu_port_checker.sv ***
// spu_port_checker: pin-role and timing properties of the serial port unit
// assumes: bound to spu_port; every property is on sys_clk
module spu_port_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // controller side
   input wire logic data_wr,
   input wire logic done_clr,
   input wire logic [7:0] port_control_reg,
   input wire logic busy,
   // pins
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic sck_oe,
   input wire logic sel_n_i,
   input wire logic sel_n_o,
   input wire logic sel_n_oe,
   input wire logic sel_pinned
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // roles never share a data pin
   AST_ROLE_PINS: assert property (!(mosi_oe && miso_oe))
      else $error("mosi and miso driven together");
   // disabled port leaves miso, mosi and sck undriven, after two settle cycles
   AST_DISABLED: assert property (!port_control_reg[0] && $past(!port_control_reg[0], 2)
      |-> !miso_oe && !mosi_oe && !sck_oe) else $error("pin driven while disabled");
   AST_SEL_OUT: assert property (sel_n_oe && $stable(port_control_reg)
      |-> sel_n_o == port_control_reg[2]) else $error("select level differs from field");
   AST_PIN_MAP: assert property ($stable(port_control_reg)
      |-> sel_pinned == (port_control_reg[3:2] != 2'h0)) else $error("select routing wrong");
   AST_BUSY_START: assert property (data_wr && !busy && port_control_reg[6]
      && port_control_reg[0] |-> ##2 busy) else $error("write did not start transfer");
   AST_DONE_TIME: assert property ($rose(busy) |-> ##[56:72] port_control_reg[7])
      else $error("done flag late");
   AST_NO_EARLY: assert property ($rose(busy) |-> !port_control_reg[7] [*8])
      else $error("done flag early");
   AST_DONE_HOLD: assert property (port_control_reg[7] && !done_clr && !$past(done_clr)
      |=> port_control_reg[7]) else $error("done flag dropped");
   AST_SEL_RST: assert property ($fell(rst) |-> port_control_reg[3:2] == 2'h0 && !sel_n_oe)
      else $error("select mode not cleared by reset");
   AST_MASTER_DROP: assert property (port_control_reg[3:2] == 2'h1 && port_control_reg[6]
      && $fell(sel_n_i) |-> ##[1:6] !port_control_reg[6]) else $error("master kept role");
endmodule

bind spu_port spu_port_checker i_spu_port_checker (.sys_clk, .rst, .data_wr, .done_clr,
   .port_control_reg, .busy, .mosi_oe, .miso_oe, .sck_oe, .sel_n_i, .sel_n_o, .sel_n_oe,
   .sel_pinned);

// *** bench/spu_far_slave.sv ***
// spu_far_slave: far spi slave answering the port in master role
// assumes: sck idles low; clr is held high between frames
module spu_far_slave (
   // link
   input wire logic sck,
   input wire logic clr,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] got
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   // sample on rise, msb arrives first
   always @(posedge sck) got <= {got[6:0], mosi};
   // advance on fall
   always @(negedge sck or posedge clr) begin
      if (clr) cnt <= 0;
      else cnt <= cnt + 1;
   end
   // sole slave; released line shows the inverse of the last bit
   assign miso = (sel_n || cnt > 7) ? ~tx[0] : tx[7 - cnt];
endmodule

// *** bench/spu_port_bench.sv ***
// spu_port_bench: scenario testbench for the serial port unit
// assumes: spu_pkg, spu_port and the bench models are compiled first
module spu_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'h0, rst = 1'h1, slave_sck = 1'h0, cfg_wr = 1'h0, data_wr = 1'h0;
   logic done_clr = 1'h0, clr = 1'h1, mosi_drv = 1'h0, sel_drv = 1'h1, far_tie = 1'h0, far_miso;
   spu_pkg::spu_cfg_t cfg_in = '0;
   logic [7:0] data_in = 8'h00, tx = 8'h00, port_control_reg, rx_data, got;
   logic busy, mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, sel_n_o, sel_n_oe, sel_pinned;
   int err_count = 0;
   int total_checks = 0;
   // pin levels from all drivers
   wire logic mosi_i = mosi_oe ? mosi_o : mosi_drv;
   wire logic miso_i = miso_oe ? miso_o : far_miso;
   wire logic sel_n_i = sel_n_oe ? sel_n_o : sel_drv;
   spu_port i_spu_port (.sys_clk, .rst, .slave_sck, .cfg_wr, .cfg_in, .data_wr, .data_in,
      .done_clr, .port_control_reg, .rx_data, .busy, .mosi_i, .mosi_o, .mosi_oe, .miso_i,
      .miso_o, .miso_oe, .sck_o, .sck_oe, .sel_n_i, .sel_n_o, .sel_n_oe, .sel_pinned);
   // a lone 3-wire far slave has its select tied low
   spu_far_slave i_spu_far_slave (.sck(sck_o), .clr, .sel_n(sel_n_i && !far_tie), .mosi(mosi_i),
      .tx, .miso(far_miso), .got);
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic chk(string name, logic [7:0] exp, logic [7:0] seen);
      total_checks++;
      if (exp !== seen) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic setcfg(logic en, logic role, logic [1:0] mode);
      cfg_in <= '{en, role, mode};
      cfg_wr <= 1'h1;
      cyc(1);
      cfg_wr <= 1'h0;
      cyc(2);
   endtask
   // one master byte; an unselected far slave returns its released level
   task automatic master_x(logic [1:0] mode, logic [7:0] d, logic [7:0] t);
      setcfg(1'h1, 1'h1, mode);
      tx = t;
      far_tie <= (mode == 2'h0);
      clr <= 1'h0;
      data_in <= d;
      data_wr <= 1'h1;
      cyc(1);
      data_wr <= 1'h0;
      for (int i = 0; i < 200 && port_control_reg[7] !== 1'h1; i++) cyc(1);
      chk("done", 8'h80, port_control_reg & 8'h80);
      // far slave is unselected in modes 01 and 11 and shows its released level
      chk("rx", mode[0] ? {8{~t[0]}} : t, rx_data);
      chk("far rx", d, got);
      chk("sel pin", {7'h0, mode != 2'h0}, {7'h0, sel_pinned});
      if (mode[1]) chk("sel out", {7'h0, mode[0]}, {7'h0, sel_n_o});
      done_clr <= 1'h1;
      clr <= 1'h1;
      cyc(1);
      done_clr <= 1'h0;
   endtask
   // one slave byte clocked by the bench with a 32 ns sck period
   task automatic slave_x(logic [1:0] mode, logic sel, logic [7:0] d, logic [7:0] exp);
      setcfg(1'h1, 1'h0, mode);
      sel_drv <= sel;
      cyc(4);
      chk("pins", {5'h0, mode == 2'h0 || !sel, 2'h0}, {5'h0, miso_oe, mosi_oe, sck_oe});
      for (int i = 0; i < 8; i++) begin
         mosi_drv = d[7 - i];
         #16 slave_sck = 1'h1;
         #16 slave_sck = 1'h0;
      end
      cyc(12);
      chk("slave rx", exp, rx_data);
      if (mode == 2'h0 || !sel) chk("slave miso", {7'h0, exp[7]}, {7'h0, miso_o});
   endtask
   // one link edge inside reset for the slave domain
   initial begin
      #16 slave_sck = 1'h1;
      #16 slave_sck = 1'h0;
   end
   initial begin
      #100000;
      err_count++;
      conclude();
   end
   initial begin
      cyc(4);
      rst <= 1'h0;
      cyc(1);
      chk("ctl reset", 8'h00, port_control_reg);
      chk("sel reset", 8'h01, {7'h0, sel_n_o});
      for (int m = 0; m < 4; m++) master_x(m[1:0], 8'hc5, 8'h3a);
      setcfg(1'h1, 1'h1, 2'h1);
      sel_drv <= 1'h0;
      cyc(8);
      chk("role", 8'h00, port_control_reg & 8'h40);
      sel_drv <= 1'h1;
      slave_x(2'h1, 1'h0, 8'h96, 8'h96);
      slave_x(2'h1, 1'h1, 8'h3c, 8'h96);
      slave_x(2'h0, 1'h1, 8'h5a, 8'h5a);
      setcfg(1'h0, 1'h0, 2'h0);
      cyc(2);
      chk("off pins", 8'h00, {5'h0, miso_oe, mosi_oe, sck_oe});
      conclude();
   end
endmodule
